// ==== rtl/rt_util_regs.sv ====
// Purpose: time-tag preset, bus-select keys and self-test word of a remote terminal
// Assumes: APB slave, zero wait states, presetn doubles as master reset
// Notes: counter, transmitters and message buffers live outside this block
`timescale 1ns/10ps
module rt_util_regs
	import rt_util_pkg::*;
(
	// clock and master reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// transmit inhibit pins, asynchronous
	input wire logic tx_a_inhibit_pin,
	input wire logic tx_b_inhibit_pin,
	// start-up test results, levels
	input wire logic addr_parity_fail,
	input wire logic mem_test_fail,
	input wire logic autoload_fail,
	// self-test loopback failures, pulses
	input wire logic loopback_a_fail,
	input wire logic loopback_b_fail,
	// decoded mode commands
	input wire logic mc_valid,
	input wire logic mc_bus_b,
	input wire logic [4:0] mc_code,
	input wire logic [15:0] mc_data,
	// time-tag counter
	input wire logic [15:0] tt_count,
	output logic tt_load,
	output logic [15:0] tt_load_value,
	// self-test word response and buffer copy
	output logic bit_word_valid,
	output logic [15:0] bit_word,
	output logic buf_copy_valid,
	output logic [15:0] buf_copy_data,
	// shutdown state and interrupt
	output logic tx_a_off_flag,
	output logic tx_b_off_flag,
	output logic rx_a_off_flag,
	output logic rx_b_off_flag,
	output logic hardware_irq_out
);
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] st);
		merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
	endfunction : merge16

	logic [15:0] preset_q;
	logic [15:0] key_a_q;
	logic [15:0] key_b_q;
	logic [3:0] cfg_q;
	logic irq_en_q;
	logic pend_q;
	logic pend_d;
	logic match_q;
	logic [5:0] user_q;
	logic loop_a_q;
	logic loop_b_q;
	logic mem_q;
	logic parity_q;
	logic load_q;
	logic flag_q;
	logic [1:0] inh_s;
	logic tx_a_d;
	logic tx_b_d;

	// address decode
	wire [9:0] idx = paddr[11:2];
	wire setup = psel && !penable;
	wire acc_wr = psel && penable && pready && pwrite;
	wire hit_pre = idx == IDX_TIMETAG;
	wire hit_ka = idx == IDX_KEY_A;
	wire hit_kb = idx == IDX_KEY_B;
	wire hit_bit = idx == IDX_SELFTEST;
	wire hit_cfg = idx == IDX_CFG;
	wire hit_ien = idx == IDX_IRQ_EN;
	wire hit_pnd = idx == IDX_IRQ_PEND;
	wire hit_cnt = idx == IDX_COUNT;
	wire mapped = hit_pre || hit_ka || hit_kb || hit_bit || hit_cfg || hit_ien
		|| hit_pnd || hit_cnt;
	wire wr_pre = acc_wr && hit_pre;
	wire wr_ka = acc_wr && hit_ka;
	wire wr_kb = acc_wr && hit_kb;
	wire wr_bit = acc_wr && hit_bit;
	wire wr_cfg = acc_wr && hit_cfg;
	wire wr_ien = acc_wr && hit_ien && pstrb[0];
	wire wr_pnd = acc_wr && hit_pnd && pstrb[0];
	wire [15:0] cfg_new = merge16({12'h000, cfg_q}, pwdata, pstrb);
	wire soft_rst = wr_cfg && pstrb[1] && pwdata[CFG_SOFT_RST];

	// self-test word image
	wire [15:0] test_word = {tx_a_off_flag, tx_b_off_flag, rx_a_off_flag, rx_b_off_flag,
		user_q, loop_a_q, loop_b_q, mem_q, parity_q, load_q, flag_q};
	wire [15:0] bit_new = merge16(test_word, pwdata, pstrb);

	// read mux
	wire [15:0] rd_word = hit_pre ? preset_q
		: hit_ka ? key_a_q
		: hit_kb ? key_b_q
		: hit_bit ? test_word
		: hit_cfg ? {12'h000, cfg_q}
		: hit_ien ? {15'h0000, irq_en_q}
		: hit_pnd ? {15'h0000, pend_q}
		: hit_cnt ? tt_count
		: REG16_RESET;

	// mode command decode; bus B command targets bus A and vice versa
	logic hit_a;
	logic hit_b;
	select_match #(.W(16)) u_match_a (
		.key(key_a_q),
		.data(mc_data),
		.auto_off(cfg_q[CFG_AUTO_OPT]),
		.hit(hit_a)
	);
	select_match #(.W(16)) u_match_b (
		.key(key_b_q),
		.data(mc_data),
		.auto_off(cfg_q[CFG_AUTO_OPT]),
		.hit(hit_b)
	);
	wire on_b = mc_valid && mc_bus_b;
	wire on_a = mc_valid && !mc_bus_b;
	wire sd_a = on_b && (mc_code == MC_TX_OFF || (mc_code == MC_SEL_OFF && hit_a));
	wire sd_b = on_a && (mc_code == MC_TX_OFF || (mc_code == MC_SEL_OFF && hit_b));
	wire ov_a = on_b && (mc_code == MC_TX_ON || (mc_code == MC_SEL_ON && hit_a));
	wire ov_b = on_a && (mc_code == MC_TX_ON || (mc_code == MC_SEL_ON && hit_b));
	wire send_bit = mc_valid && mc_code == MC_SEND_BIT && !cfg_q[CFG_ALT_SEL];

	// inhibit pins cross into pclk
	sync2 #(.W(2)) u_inh_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({tx_a_inhibit_pin, tx_b_inhibit_pin}),
		.sync_out(inh_s)
	);

	// pin wins, then shutdown, then override; soft reset tracks the pin
	always_comb
	begin
		if (soft_rst)
		begin
			tx_a_d = inh_s[1] || sd_a;
			tx_b_d = inh_s[0] || sd_b;
		end
		else
		begin
			tx_a_d = inh_s[1] || sd_a || (tx_a_off_flag && !ov_a);
			tx_b_d = inh_s[0] || sd_b || (tx_b_off_flag && !ov_b);
		end
	end

	// timer match fires once per arrival at the preset value
	wire match_now = tt_count == preset_q;
	wire match_evt = match_now && !match_q && irq_en_q;
	assign pend_d = match_evt || (pend_q && !(wr_pnd && pwdata[IRQ_MATCH]));

	// apb answer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			prdata <= {16'h0000, rd_word};
			pready <= setup;
			pslverr <= setup && !mapped;
		end
	end

	// host registers untouched by soft reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			preset_q <= REG16_RESET;
			key_a_q <= REG16_RESET;
			key_b_q <= REG16_RESET;
			cfg_q <= CFG_RESET;
			irq_en_q <= 1'b0;
		end
		else
		begin
			if (wr_pre)
				preset_q <= merge16(preset_q, pwdata, pstrb);
			if (wr_ka)
				key_a_q <= merge16(key_a_q, pwdata, pstrb);
			if (wr_kb)
				key_b_q <= merge16(key_b_q, pwdata, pstrb);
			if (wr_cfg)
				cfg_q <= cfg_new[3:0];
			if (wr_ien)
				irq_en_q <= pwdata[IRQ_MATCH];
		end
	end

	// time-tag preload and match interrupt
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tt_load <= 1'b0;
			tt_load_value <= REG16_RESET;
			match_q <= 1'b0;
			pend_q <= 1'b0;
			hardware_irq_out <= 1'b0;
		end
		else
		begin
			tt_load <= wr_cfg && !cfg_q[CFG_PRELOAD] && cfg_new[CFG_PRELOAD];
			tt_load_value <= preset_q;
			match_q <= match_now;
			pend_q <= pend_d;
			hardware_irq_out <= pend_d;
		end
	end

	// shutdown bits
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_a_off_flag <= 1'b0;
			tx_b_off_flag <= 1'b0;
			rx_a_off_flag <= 1'b0;
			rx_b_off_flag <= 1'b0;
		end
		else
		begin
			tx_a_off_flag <= tx_a_d;
			tx_b_off_flag <= tx_b_d;
			if (soft_rst)
			begin
				rx_a_off_flag <= sd_a && cfg_q[CFG_RX_FOLLOW];
				rx_b_off_flag <= sd_b && cfg_q[CFG_RX_FOLLOW];
			end
			else
			begin
				rx_a_off_flag <= rx_a_off_flag || (sd_a && cfg_q[CFG_RX_FOLLOW]);
				rx_b_off_flag <= rx_b_off_flag || (sd_b && cfg_q[CFG_RX_FOLLOW]);
			end
		end
	end

	// remaining self-test bits; hardware sets beat host writes and soft reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			user_q <= 6'h00;
			loop_a_q <= 1'b0;
			loop_b_q <= 1'b0;
			mem_q <= 1'b0;
			parity_q <= 1'b0;
			load_q <= 1'b0;
			flag_q <= 1'b0;
		end
		else
		begin
			if (wr_bit)
				user_q <= bit_new[BIT_USER_HI:BIT_USER_LO];
			if (loopback_a_fail)
				loop_a_q <= 1'b1;
			else if (soft_rst)
				loop_a_q <= 1'b0;
			else if (wr_bit)
				loop_a_q <= bit_new[BIT_LOOP_A];
			if (loopback_b_fail)
				loop_b_q <= 1'b1;
			else if (soft_rst)
				loop_b_q <= 1'b0;
			else if (wr_bit)
				loop_b_q <= bit_new[BIT_LOOP_B];
			mem_q <= mem_q || mem_test_fail;
			parity_q <= parity_q || addr_parity_fail;
			load_q <= load_q || autoload_fail;
			if (mc_valid && mc_code == MC_FLAG_OFF)
				flag_q <= 1'b1;
			else if (soft_rst)
				flag_q <= 1'b0;
			else if (mc_valid && mc_code == MC_FLAG_ON)
				flag_q <= 1'b0;
		end
	end

	// test word goes out first, buffer copy follows a cycle later
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bit_word_valid <= 1'b0;
			bit_word <= REG16_RESET;
			buf_copy_valid <= 1'b0;
			buf_copy_data <= REG16_RESET;
		end
		else
		begin
			bit_word_valid <= send_bit;
			if (send_bit)
				bit_word <= test_word;
			buf_copy_valid <= bit_word_valid;
			if (bit_word_valid)
				buf_copy_data <= bit_word;
		end
	end
endmodule : rt_util_regs

// ==== inc/rt_util_pkg.sv ====
// Purpose: shared constants for the remote-terminal utility register group
// Assumes: register indices are word indices; byte address is index times four
// Notes: mode codes are decimal mode command numbers
package rt_util_pkg;
	// printed register indices
	localparam logic [9:0] IDX_TIMETAG = 10'h011;
	localparam logic [9:0] IDX_KEY_A = 10'h012;
	localparam logic [9:0] IDX_KEY_B = 10'h013;
	localparam logic [9:0] IDX_SELFTEST = 10'h014;
	// extra control and status words
	localparam logic [9:0] IDX_CFG = 10'h020;
	localparam logic [9:0] IDX_IRQ_EN = 10'h021;
	localparam logic [9:0] IDX_IRQ_PEND = 10'h022;
	localparam logic [9:0] IDX_COUNT = 10'h023;
	// configuration word fields
	localparam int CFG_PRELOAD = 0;
	localparam int CFG_AUTO_OPT = 1;
	localparam int CFG_ALT_SEL = 2;
	localparam int CFG_RX_FOLLOW = 3;
	localparam int CFG_SOFT_RST = 15;
	localparam logic [3:0] CFG_RESET = 4'h0;
	localparam int IRQ_MATCH = 0;
	// self-test word fields
	localparam int BIT_TX_A = 15;
	localparam int BIT_TX_B = 14;
	localparam int BIT_RX_A = 13;
	localparam int BIT_RX_B = 12;
	localparam int BIT_USER_HI = 11;
	localparam int BIT_USER_LO = 6;
	localparam int BIT_LOOP_A = 5;
	localparam int BIT_LOOP_B = 4;
	localparam int BIT_MEM = 3;
	localparam int BIT_PARITY = 2;
	localparam int BIT_LOAD = 1;
	localparam int BIT_FLAG = 0;
	localparam logic [15:0] SELFTEST_WR_MASK = 16'h0FF0;
	localparam logic [15:0] REG16_RESET = 16'h0000;
	// mode command codes
	localparam logic [4:0] MC_TX_OFF = 5'h04;
	localparam logic [4:0] MC_TX_ON = 5'h05;
	localparam logic [4:0] MC_FLAG_OFF = 5'h06;
	localparam logic [4:0] MC_FLAG_ON = 5'h07;
	localparam logic [4:0] MC_SEND_BIT = 5'h13;
	localparam logic [4:0] MC_SEL_OFF = 5'h14;
	localparam logic [4:0] MC_SEL_ON = 5'h15;
endpackage : rt_util_pkg

// ==== rtl/sync2.sv ====
// Purpose: two-flop synchroniser for asynchronous level inputs
// Assumes: inputs are slow levels, no multi-bit coherence needed
// Notes: only the second stage may be read by other logic
`timescale 1ns/10ps
module sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// levels
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_q <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : sync2

// ==== rtl/select_match.sv ====
// Purpose: decides whether a selected-shutdown mode word hits one inactive bus
// Assumes: key comes from a host register, data from the received mode word
// Notes: full-width compare; a near miss must not touch the self-test word
`timescale 1ns/10ps
module select_match #(
	parameter int W = 16
) (
	// compare operands
	input wire logic [W-1:0] key,
	input wire logic [W-1:0] data,
	// host handles the commands itself when set
	input wire logic auto_off,
	output logic hit
);
	assign hit = !auto_off && (key == data);
endmodule : select_match

// ==== tb/rt_util_regs_chk.sv ====
// Purpose: port-level checks for the utility register group
// Assumes: zero-wait APB slave as handed over
// Notes: the sent word carries the flags as they stood before its send edge
`timescale 1ns/10ps
module rt_util_regs_chk
	import rt_util_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	// mode commands and time tag
	input wire logic mc_valid,
	input wire logic mc_bus_b,
	input wire logic [4:0] mc_code,
	input wire logic [15:0] tt_count,
	input wire logic tt_load,
	input wire logic [15:0] tt_load_value,
	// results
	input wire logic bit_word_valid,
	input wire logic [15:0] bit_word,
	input wire logic buf_copy_valid,
	input wire logic [15:0] buf_copy_data,
	input wire logic tx_a_off_flag,
	input wire logic tx_b_off_flag,
	input wire logic rx_a_off_flag,
	input wire logic rx_b_off_flag,
	input wire logic hardware_irq_out
);
	wire logic acc_w = psel && penable && pwrite && pstrb[0] && pwdata[0];
	wire logic wr_cfg = acc_w && paddr[11:2] == IDX_CFG;
	wire logic clr_pend = acc_w && paddr[11:2] == IDX_IRQ_PEND;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_copy_follows: assert property (bit_word_valid |=> buf_copy_valid
		&& buf_copy_data == $past(bit_word)) else $error("buffer copy wrong");
	a_word_flags: assert property (bit_word_valid |-> bit_word[15:12] ==
		$past({tx_a_off_flag, tx_b_off_flag, rx_a_off_flag, rx_b_off_flag}))
		else $error("word flags");
	a_load_cause: assert property (tt_load |-> $past(wr_cfg) || $past(wr_cfg, 2))
		else $error("load without trigger");
	a_irq_cause: assert property ($rose(hardware_irq_out) |->
		$past(tt_count) == $past(tt_load_value)) else $error("irq without match");
	a_irq_holds: assert property (hardware_irq_out && !clr_pend |=> hardware_irq_out)
		else $error("irq dropped");
	a_mc4_inactive: assert property (mc_valid && mc_code == MC_TX_OFF |=>
		($past(mc_bus_b) ? tx_a_off_flag : tx_b_off_flag)) else $error("wrong bus");
	a_reset_clear: assert property ($rose(presetn) |-> !rx_a_off_flag && !rx_b_off_flag
		&& !hardware_irq_out) else $error("reset state");
endmodule : rt_util_regs_chk

bind rt_util_regs rt_util_regs_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pstrb, .pready, .mc_valid, .mc_bus_b, .mc_code, .tt_count, .tt_load,
	.tt_load_value, .bit_word_valid, .bit_word, .buf_copy_valid, .buf_copy_data,
	.tx_a_off_flag, .tx_b_off_flag, .rx_a_off_flag, .rx_b_off_flag, .hardware_irq_out);

// ==== tb/rt_bc_model.sv ====
// Purpose: bus controller and time-tag counter standing beside the block
// Assumes: commands already decoded, one per call
// Notes: mode data shows inverted value once released
`timescale 1ns/10ps
module rt_bc_model
	import rt_util_pkg::*;
(
	// clock
	input wire logic pclk,
	// from the block
	input wire logic tt_load,
	input wire logic [15:0] tt_load_value,
	input wire logic bit_word_valid,
	input wire logic [15:0] bit_word,
	input wire logic buf_copy_valid,
	input wire logic [15:0] buf_copy_data,
	// to the block
	output logic mc_valid,
	output logic mc_bus_b,
	output logic [4:0] mc_code,
	output logic [15:0] mc_data,
	output logic [15:0] tt_count
);
	int words = 0;
	logic [15:0] loaded = 16'h0000;
	logic [15:0] last_word = 16'h0000;
	logic [15:0] last_copy = 16'h0000;
	initial
	begin
		mc_valid = 0;
		mc_bus_b = 0;
		mc_code = 5'h00;
		mc_data = 16'hFFFF;
		tt_count = 16'h0000;
	end
	always @(posedge pclk)
	begin
		tt_count <= tt_load ? tt_load_value : tt_count + 16'h0001;
		if (tt_load) loaded <= tt_load_value;
		if (bit_word_valid) words++;
		if (bit_word_valid) last_word <= bit_word;
		if (buf_copy_valid) last_copy <= buf_copy_data;
	end
	task automatic send(input logic b, input logic [4:0] c, input logic [15:0] d);
		@(posedge pclk);
		mc_valid <= 1;
		mc_bus_b <= b;
		mc_code <= c;
		mc_data <= d;
		@(posedge pclk);
		mc_valid <= 0;
		mc_data <= ~d;
		@(negedge pclk);
	endtask : send
endmodule : rt_bc_model

// ==== tb/rt_util_regs_tb.sv ====
// Purpose: self-checking bench for the utility register group
// Assumes: zero-wait APB, start-up fail inputs raised only in the last test
// Notes: preset chosen far from the free-running count to avoid stray matches
`timescale 1ns/10ps
module rt_util_regs_tb
	import rt_util_pkg::*;
;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] pstrb = 4'h0;
	logic tx_a_inhibit_pin = 0;
	logic loopback_a_fail = 0;
	logic tx_b_inhibit_pin = 0;
	logic loopback_b_fail = 0;
	logic addr_parity_fail = 0;
	logic mem_test_fail = 0;
	logic autoload_fail = 0;
	logic [31:0] prdata;
	logic pready, pslverr, mc_valid, mc_bus_b, tt_load, bit_word_valid, buf_copy_valid;
	logic tx_a_off_flag, tx_b_off_flag, rx_a_off_flag, rx_b_off_flag, hardware_irq_out;
	logic [4:0] mc_code;
	logic [15:0] mc_data, tt_count, tt_load_value, bit_word, buf_copy_data;
	int mismatches = 0;
	int checks = 0;
	rt_util_regs DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .tx_a_inhibit_pin, .tx_b_inhibit_pin,
		.addr_parity_fail, .mem_test_fail, .autoload_fail,
		.loopback_a_fail, .loopback_b_fail, .mc_valid, .mc_bus_b, .mc_code, .mc_data,
		.tt_count, .tt_load, .tt_load_value, .bit_word_valid, .bit_word, .buf_copy_valid,
		.buf_copy_data, .tx_a_off_flag, .tx_b_off_flag, .rx_a_off_flag, .rx_b_off_flag,
		.hardware_irq_out);
	rt_bc_model bc (.pclk, .tt_load, .tt_load_value, .bit_word_valid, .bit_word,
		.buf_copy_valid, .buf_copy_data, .mc_valid, .mc_bus_b, .mc_code, .mc_data, .tt_count);
	initial
	begin
		forever #50 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [9:0] i, input logic [15:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {16'h0000, d};
		pstrb <= 4'h3;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task automatic wr(input logic [9:0] i, input logic [15:0] d);
		logic [31:0] r;
		logic e;
		apb(1, i, d, r, e);
	endtask : wr
	task automatic rdc(input logic [9:0] i, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(0, i, 16'h0000, r, e);
		chk(r, x);
	endtask : rdc
	task automatic t_regs;
		logic [31:0] r;
		logic e;
		for (int i = 0; i < 4; i++) rdc(10'(IDX_TIMETAG + i), 0);
		for (int i = 0; i < 3; i++) wr(10'(IDX_TIMETAG + i), 16'(16'hA5C3 + i));
		wr(IDX_CFG, 16'h8000);
		for (int i = 0; i < 3; i++) rdc(10'(IDX_TIMETAG + i), 16'hA5C3 + i);
		apb(0, 10'h3FF, 16'h0000, r, e);
		chk(e, 1);
		chk(r, 0);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_selftest;
		wr(IDX_SELFTEST, 16'hFFCF);
		rdc(IDX_SELFTEST, 16'h0FC0);
		@(posedge pclk);
		loopback_a_fail <= 1;
		loopback_b_fail <= 1;
		tx_a_inhibit_pin <= 1;
		tx_b_inhibit_pin <= 1;
		@(posedge pclk);
		loopback_a_fail <= 0;
		loopback_b_fail <= 0;
		repeat (4) @(posedge pclk);
		rdc(IDX_SELFTEST, 16'hCFF0);
		tx_a_inhibit_pin <= 0;
		tx_b_inhibit_pin <= 0;
		repeat (4) @(posedge pclk);
		wr(IDX_CFG, 16'h8000);
		rdc(IDX_SELFTEST, 16'h0FC0);
		$display("t_selftest done");
	endtask : t_selftest
	task automatic t_shutdown;
		logic [24:0] st [7];
		logic o, b;
		logic [4:0] c;
		logic [15:0] d;
		logic [1:0] x;
		st = '{{2'b01, MC_SEL_OFF, 16'h1234, 2'b10}, {2'b00, MC_SEL_OFF, 16'hABCC, 2'b10},
			{2'b00, MC_SEL_OFF, 16'hABCD, 2'b11}, {2'b01, MC_SEL_ON, 16'h1234, 2'b01},
			{2'b10, MC_SEL_ON, 16'hABCD, 2'b01}, {2'b00, MC_SEL_ON, 16'hABCD, 2'b00},
			{2'b00, MC_TX_OFF, 16'h0000, 2'b01}};
		wr(IDX_KEY_A, 16'h1234);
		wr(IDX_KEY_B, 16'hABCD);
		for (int i = 0; i < 7; i++)
		begin
			{o, b, c, d, x} = st[i];
			wr(IDX_CFG, {14'h0000, o, 1'b0});
			bc.send(b, c, d);
			chk({tx_a_off_flag, tx_b_off_flag}, x);
		end
		$display("t_shutdown done");
	endtask : t_shutdown
	task automatic t_bitword;
		int n;
		bc.send(0, MC_FLAG_OFF, 16'h0000);
		bc.send(0, MC_SEND_BIT, 16'h0000);
		repeat (3) @(posedge pclk);
		chk(bc.last_word, 16'h4FC1);
		chk(bc.last_copy, 16'h4FC1);
		bc.send(1, MC_FLAG_ON, 16'h0000);
		rdc(IDX_SELFTEST, 16'h4FC0);
		n = bc.words;
		wr(IDX_CFG, 16'h0004);
		bc.send(0, MC_SEND_BIT, 16'h0000);
		repeat (3) @(posedge pclk);
		chk(bc.words, n);
		wr(IDX_CFG, 16'h0000);
		$display("t_bitword done");
	endtask : t_bitword
	task automatic t_timetag;
		int n;
		wr(IDX_TIMETAG, 16'hF000);
		wr(IDX_IRQ_EN, 16'h0001);
		wr(IDX_CFG, 16'h0001);
		n = 0;
		while (hardware_irq_out !== 1'b1 && n < 10)
		begin
			@(posedge pclk);
			n++;
		end
		chk(bc.loaded, 16'hF000);
		rdc(IDX_IRQ_PEND, 1);
		wr(IDX_IRQ_PEND, 16'h0001);
		rdc(IDX_IRQ_PEND, 0);
		chk(hardware_irq_out, 0);
		$display("t_timetag done");
	endtask : t_timetag
	task automatic t_reset;
		wr(IDX_CFG, 16'h0008);
		addr_parity_fail <= 1;
		mem_test_fail <= 1;
		autoload_fail <= 1;
		tx_b_inhibit_pin <= 1;
		bc.send(1, MC_TX_OFF, 16'h0000);
		chk({rx_a_off_flag, rx_b_off_flag}, 2'b10);
		rdc(IDX_SELFTEST, 16'hEFCE);
		addr_parity_fail <= 0;
		mem_test_fail <= 0;
		autoload_fail <= 0;
		wr(IDX_CFG, 16'h8000);
		rdc(IDX_SELFTEST, 16'h4FCE);
		presetn <= 0;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		repeat (4) @(posedge pclk);
		rdc(IDX_SELFTEST, 16'h4000);
		rdc(IDX_KEY_A, 0);
		tx_b_inhibit_pin <= 0;
		$display("t_reset done");
	endtask : t_reset
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		repeat (4000) @(posedge pclk);
		mismatches++;
		tally_and_finish;
	end
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		t_regs;
		t_selftest;
		t_shutdown;
		t_bitword;
		t_timetag;
		t_reset;
		tally_and_finish;
	end
endmodule : rt_util_regs_tb
